/* rtl/spf_pkg.sv */
// Constants, command patterns and state types of the self-programming sequencer
package spf_pkg;
    // Clock and flash programming time
    localparam int unsigned CLK_PERIOD_PS = 5000;
    localparam int unsigned PROG_TIME_MIN_NS = 3700000;
    localparam int unsigned PROG_TIME_MAX_NS = 4500000;
    localparam int unsigned PROG_CYCLES = (PROG_TIME_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    ////////////////////////////////////////////////////////////////////////////
    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_PTR_LO = 8'h04;
    localparam logic [7:0] OFS_PTR_HI = 8'h08;
    localparam logic [7:0] OFS_DATA_LO = 8'h0C;
    localparam logic [7:0] OFS_DATA_HI = 8'h10;
    // Control field positions
    localparam int unsigned BIT_ENABLE = 0;
    localparam int unsigned BIT_ERASE = 1;
    localparam int unsigned BIT_WRITE = 2;
    localparam int unsigned BIT_READ_FUSE_LOCK_BIT = 3;
    localparam int unsigned BIT_CLEAR_PAGE_BUFFER_BIT = 4;
    localparam int unsigned BIT_RWW = 6;
    // Patterns of the low five control bits; all but CMD_NONE are legal
    localparam logic [4:0] CMD_NONE = 5'h00;
    localparam logic [4:0] CMD_STORE = 5'h01;
    localparam logic [4:0] CMD_ERASE = 5'h03;
    localparam logic [4:0] CMD_WRITE = 5'h05;
    localparam logic [4:0] CMD_READ_FUSE_LOCK_BIT = 5'h09;
    localparam logic [4:0] CMD_CLEAR_PAGE_BUFFER_BIT = 5'h11;
    // Arming windows in cycles
    localparam logic [2:0] STORE_WINDOW = 3'h4;
    localparam logic [2:0] LOAD_WINDOW = 3'h3;
    ////////////////////////////////////////////////////////////////////////////
    // Pointer split: word in page and page number
    localparam int unsigned PAGE_WORDS = 32;
    localparam int unsigned WORD_LSB = 1;
    localparam int unsigned WORD_W = 5;
    localparam int unsigned PAGE_LSB = 6;
    localparam int unsigned PAGE_W = 10;
    localparam logic [15:0] BUF_EMPTY = 16'hFFFF;
    // Configuration read addresses
    localparam logic [15:0] CFG_FUSE_LOW = 16'h0000;
    localparam logic [15:0] CFG_LOCK = 16'h0001;
    localparam logic [15:0] CFG_FUSE_EXT = 16'h0002;
    localparam logic [15:0] CFG_FUSE_HIGH = 16'h0003;
    localparam logic [7:0] CFG_UNMAPPED = 8'hFF;
    localparam logic [5:0] LOCK_UNUSED = 6'h3F;
    typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_WRITE} op_state_e;
endpackage

/* rtl/pbuf_if.sv */
// Port bundle between the sequencer and its temporary page buffer
`timescale 1ns/1ps
interface pbuf_if;
    logic wr_en;
    logic [4:0] wr_idx;
    logic [15:0] wr_data;
    logic [4:0] rd_idx;
    logic [15:0] rd_data;
    logic clear;
    modport ctrl(output wr_en, output wr_idx, output wr_data, output rd_idx, output clear,
        input rd_data);
    modport mem(input wr_en, input wr_idx, input wr_data, input rd_idx, input clear,
        output rd_data);
endinterface

/* rtl/page_buffer_mem.sv */
// Temporary page buffer: write-once words, bulk clear, registered read
`timescale 1ns/1ps
module page_buffer_mem (
    input wire logic clk,
    input wire logic rst_n,
    pbuf_if.mem bus
);
    import spf_pkg::*;
    logic [15:0] mem_q [PAGE_WORDS];
    logic [PAGE_WORDS-1:0] valid_q;
    logic [15:0] rd_data_q;
    wire rd_valid = valid_q[bus.rd_idx];
    wire wr_ok = bus.wr_en && !valid_q[bus.wr_idx];

    // Valid bits and read data see reset; word storage needs none
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            valid_q <= '0;
        end else if (bus.clear) begin
            valid_q <= '0;
        end else if (wr_ok) begin
            valid_q[bus.wr_idx] <= 1'b1;
        end
    end

    // A word is written once; a second store to it is dropped until a clear
    always_ff @(posedge clk) begin
        if (wr_ok) begin
            mem_q[bus.wr_idx] <= bus.wr_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data_q <= BUF_EMPTY;
        end else begin
            rd_data_q <= rd_valid ? mem_q[bus.rd_idx] : BUF_EMPTY;
        end
    end

    assign bus.rd_data = rd_data_q;
endmodule

/* rtl/op_timer.sv */
// Flash programming timer: runs a fixed count after a start pulse
`timescale 1ns/1ps
module op_timer #(
    parameter int unsigned CYCLES = spf_pkg::PROG_CYCLES
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    output logic busy,
    output logic done
);
    import spf_pkg::*;
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LOAD = CW'(CYCLES);
    localparam logic [CW-1:0] ONE = CW'(1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (start && cnt_q == '0) begin
            cnt_q <= LOAD;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - ONE;
        end
    end

    assign busy = cnt_q != '0;
    assign done = cnt_q == ONE;
endmodule

/* rtl/self_program_flash_ctrl.sv */
// Self-programming sequencer: control register, page ops, configuration read
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module self_program_flash_ctrl #(
    parameter int unsigned PROG_CYCLES_P = spf_pkg::PROG_CYCLES
) (
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic NPOR,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic SPM_EXEC,
    input wire logic LPM_EXEC,
    output logic [7:0] LPM_DATA,
    output logic LPM_VALID,
    input wire logic EEPROM_WRITE_BUSY,
    input wire logic [7:0] FUSE_LOW_PROG,
    input wire logic [7:0] FUSE_HIGH_PROG,
    input wire logic [7:0] FUSE_EXT_PROG,
    input wire logic [1:0] LOCK_PROG,
    output logic CORE_STALL,
    output logic [15:0] FLASH_RD_ADDR,
    input wire logic [7:0] FLASH_RD_DATA,
    output logic FLASH_ERASE,
    output logic FLASH_WR_VALID,
    output logic [spf_pkg::PAGE_W-1:0] FLASH_PAGE,
    output logic [spf_pkg::WORD_W-1:0] FLASH_WR_WORD,
    output logic [15:0] FLASH_WR_DATA
);
    import spf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Reset synchronisers; power-on reset also forces the system reset
    logic [1:0] sys_sync_q;
    logic [1:0] por_sync_q;
    logic sys_rst_n;
    logic por_rst_n;
    always_ff @(posedge MCLK or negedge NRST or negedge NPOR) begin
        if (!NRST || !NPOR) begin
            sys_sync_q <= 2'h0;
        end else begin
            sys_sync_q <= {sys_sync_q[0], 1'b1};
        end
    end
    always_ff @(posedge MCLK or negedge NPOR) begin
        if (!NPOR) begin
            por_sync_q <= 2'h0;
        end else begin
            por_sync_q <= {por_sync_q[0], 1'b1};
        end
    end
    assign sys_rst_n = sys_sync_q[1];
    assign por_rst_n = por_sync_q[1];

    // Programmed fuse cells read back as zero
    function automatic logic [7:0] cfg_byte(input logic [15:0] ptr, input logic [7:0] flo,
        input logic [7:0] fhi, input logic [7:0] fex, input logic [1:0] lck);
        logic [7:0] r;
        r = CFG_UNMAPPED;
        case (ptr)
            CFG_FUSE_LOW: r = ~flo;
            CFG_LOCK: r = {LOCK_UNUSED, ~lck};
            CFG_FUSE_EXT: r = ~fex;
            CFG_FUSE_HIGH: r = ~fhi;
            default: r = CFG_UNMAPPED;
        endcase
        return r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Registers and APB decode
    logic [4:0] cmd_q;
    logic [2:0] win_q;
    logic [15:0] ptr_q;
    logic [15:0] dword_q;
    logic [31:0] prdata_q;
    logic [7:0] lpm_data_q;
    logic lpm_valid_q;
    op_state_e op_q;
    logic [PAGE_W-1:0] page_q;
    logic [5:0] str_idx_q;
    logic str_vld_q;
    logic [WORD_W-1:0] str_word_q;
    logic erase_q;
    logic tmr_busy;
    logic tmr_done;
    pbuf_if pbuf ();

    wire busy = op_q != OP_IDLE;
    wire apb_setup = PSEL && !PENABLE;
    wire apb_access = PSEL && PENABLE;
    wire addr_hit = PADDR == OFS_CTRL || PADDR == OFS_PTR_LO || PADDR == OFS_PTR_HI
        || PADDR == OFS_DATA_LO || PADDR == OFS_DATA_HI;
    wire apb_wr = apb_access && PWRITE && addr_hit;
    wire ctrl_wr = apb_wr && PADDR == OFS_CTRL;
    wire [4:0] cmd_in = PWDATA[4:0];
    wire cmd_legal = cmd_in == CMD_STORE || cmd_in == CMD_ERASE || cmd_in == CMD_WRITE
        || cmd_in == CMD_READ_FUSE_LOCK_BIT || cmd_in == CMD_CLEAR_PAGE_BUFFER_BIT;
    wire ctrl_accept = ctrl_wr && cmd_legal && !EEPROM_WRITE_BUSY && !busy;
    wire armed = win_q != 3'h0;
    wire spm_take = SPM_EXEC && armed && cmd_q != CMD_READ_FUSE_LOCK_BIT && !EEPROM_WRITE_BUSY;
    wire lpm_cfg = LPM_EXEC && armed && cmd_q == CMD_READ_FUSE_LOCK_BIT && !EEPROM_WRITE_BUSY;
    wire start_erase = spm_take && cmd_q == CMD_ERASE;
    wire start_write = spm_take && cmd_q == CMD_WRITE;
    wire wr_done = tmr_done && op_q == OP_WRITE;
    wire [7:0] status = {1'b0, 1'b0, 1'b0, cmd_q[BIT_CLEAR_PAGE_BUFFER_BIT], cmd_q[BIT_READ_FUSE_LOCK_BIT],
        cmd_q[BIT_WRITE] || op_q == OP_WRITE, cmd_q[BIT_ERASE] || op_q == OP_ERASE,
        cmd_q[BIT_ENABLE] || busy};
    wire [31:0] rd_mux = PADDR == OFS_CTRL ? {24'h00_0000, status}
        : PADDR == OFS_PTR_LO ? {24'h00_0000, ptr_q[7:0]}
        : PADDR == OFS_PTR_HI ? {24'h00_0000, ptr_q[15:8]}
        : PADDR == OFS_DATA_LO ? {24'h00_0000, dword_q[7:0]}
        : PADDR == OFS_DATA_HI ? {24'h00_0000, dword_q[15:8]} : 32'h0000_0000;

    // Zero-wait slave: read data is captured in the setup cycle
    assign PREADY = 1'b1;
    assign PSLVERR = apb_access && !addr_hit;
    assign PRDATA = prdata_q;

    always_ff @(posedge MCLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            prdata_q <= 32'h0000_0000;
            ptr_q <= 16'h0000;
            dword_q <= 16'h0000;
        end else begin
            if (apb_setup && !PWRITE) begin
                prdata_q <= rd_mux;
            end
            if (apb_wr && PADDR == OFS_PTR_LO) begin
                ptr_q[7:0] <= PWDATA[7:0];
            end
            if (apb_wr && PADDR == OFS_PTR_HI) begin
                ptr_q[15:8] <= PWDATA[7:0];
            end
            if (apb_wr && PADDR == OFS_DATA_LO) begin
                dword_q[7:0] <= PWDATA[7:0];
            end
            if (apb_wr && PADDR == OFS_DATA_HI) begin
                dword_q[15:8] <= PWDATA[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arming window; a taken store or read ends it, else it lapses
    always_ff @(posedge MCLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            win_q <= 3'h0;
            cmd_q <= CMD_NONE;
        end else if (ctrl_accept) begin
            win_q <= cmd_in == CMD_READ_FUSE_LOCK_BIT ? LOAD_WINDOW : STORE_WINDOW;
            cmd_q <= cmd_in;
        end else if (spm_take || lpm_cfg) begin
            win_q <= 3'h0;
            cmd_q <= (start_erase || start_write) ? cmd_q : CMD_NONE;
        end else if (tmr_done) begin
            cmd_q <= CMD_NONE;
        end else if (armed) begin
            win_q <= win_q - 3'h1;
            if (win_q == 3'h1 && !busy) begin
                cmd_q <= CMD_NONE;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Load path: configuration byte when armed for CMD_READ_FUSE_LOCK_BIT, flash byte otherwise
    assign FLASH_RD_ADDR = ptr_q;
    always_ff @(posedge MCLK or negedge sys_rst_n) begin
        if (!sys_rst_n) begin
            lpm_data_q <= 8'h00;
            lpm_valid_q <= 1'b0;
        end else begin
            lpm_valid_q <= LPM_EXEC;
            if (lpm_cfg) begin
                lpm_data_q <= cfg_byte(ptr_q, FUSE_LOW_PROG, FUSE_HIGH_PROG, FUSE_EXT_PROG,
                    LOCK_PROG);
            end else if (LPM_EXEC) begin
                lpm_data_q <= FLASH_RD_DATA;
            end
        end
    end
    assign LPM_DATA = lpm_data_q;
    assign LPM_VALID = lpm_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    // Flash operation engine; only power-on reset stops it, so a system reset lets it finish
    always_ff @(posedge MCLK or negedge por_rst_n) begin
        if (!por_rst_n) begin
            op_q <= OP_IDLE;
            page_q <= '0;
            erase_q <= 1'b0;
        end else begin
            erase_q <= start_erase;
            unique case (op_q)
                OP_IDLE: begin
                    if (start_erase || start_write) begin
                        op_q <= start_erase ? OP_ERASE : OP_WRITE;
                        page_q <= ptr_q[PAGE_LSB +: PAGE_W];
                    end
                end
                OP_ERASE, OP_WRITE: begin
                    if (tmr_done) begin
                        op_q <= OP_IDLE;
                    end
                end
            endcase
        end
    end

    // Stream buffer words to the array early in the write
    always_ff @(posedge MCLK or negedge por_rst_n) begin
        if (!por_rst_n) begin
            str_idx_q <= 6'h00;
            str_vld_q <= 1'b0;
            str_word_q <= '0;
        end else begin
            str_vld_q <= op_q == OP_WRITE && !str_idx_q[5];
            str_word_q <= str_idx_q[WORD_W-1:0];
            if (op_q != OP_WRITE) begin
                str_idx_q <= 6'h00;
            end else if (!str_idx_q[5]) begin
                str_idx_q <= str_idx_q + 6'h01;
            end
        end
    end

    op_timer #(.CYCLES(PROG_CYCLES_P)) u_timer (
        .clk(MCLK),
        .rst_n(por_rst_n),
        .start(start_erase || start_write),
        .busy(tmr_busy),
        .done(tmr_done)
    );

    assign CORE_STALL = busy;
    assign FLASH_ERASE = erase_q;
    assign FLASH_PAGE = page_q;
    assign FLASH_WR_VALID = str_vld_q;
    assign FLASH_WR_WORD = str_word_q;
    assign FLASH_WR_DATA = pbuf.rd_data;

    ////////////////////////////////////////////////////////////////////////////
    // Page buffer; system reset clears it only once no write still needs it
    assign pbuf.wr_en = spm_take && cmd_q == CMD_STORE;
    assign pbuf.wr_idx = ptr_q[WORD_LSB +: WORD_W];
    assign pbuf.wr_data = dword_q;
    assign pbuf.rd_idx = str_idx_q[WORD_W-1:0];
    assign pbuf.clear = (spm_take && cmd_q == CMD_CLEAR_PAGE_BUFFER_BIT) || wr_done || (!sys_rst_n && op_q != OP_WRITE);

    page_buffer_mem u_pbuf (
        .clk(MCLK),
        .rst_n(por_rst_n),
        .bus(pbuf.mem)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    logic [31:0] stall_len_q;
    always_ff @(posedge MCLK or negedge por_rst_n) begin
        if (!por_rst_n) begin
            stall_len_q <= 32'h0000_0000;
        end else begin
            stall_len_q <= CORE_STALL ? stall_len_q + 32'h0000_0001 : 32'h0000_0000;
        end
    end
    a_write_start: assert property (@(posedge MCLK) disable iff (!por_rst_n)
        start_write |=> op_q == OP_WRITE && CORE_STALL)
        else $error("page write did not start");
    a_erase_start: assert property (@(posedge MCLK) disable iff (!por_rst_n)
        start_erase |=> FLASH_ERASE && op_q == OP_ERASE)
        else $error("page erase did not start");
    a_stall_hold: assert property (@(posedge MCLK) disable iff (!por_rst_n)
        $rose(CORE_STALL) |-> CORE_STALL[*8])
        else $error("stall dropped early");
    a_op_length: assert property (@(posedge MCLK) disable iff (!por_rst_n)
        $fell(CORE_STALL) |-> $past(stall_len_q) == 32'(PROG_CYCLES_P) - 32'h0000_0001)
        else $error("flash operation length wrong");
    a_eeprom_block: assert property (@(posedge MCLK) disable iff (!por_rst_n)
        EEPROM_WRITE_BUSY && op_q == OP_IDLE |=> op_q == OP_IDLE)
        else $error("command ran during eeprom write");
    a_read_lapse: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        ctrl_accept && cmd_in == CMD_READ_FUSE_LOCK_BIT ##1 (!LPM_EXEC && !ctrl_wr)[*3] |=> cmd_q == CMD_NONE)
        else $error("read arm did not lapse");
    a_lock_read: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        lpm_cfg && ptr_q == CFG_LOCK |=> LPM_VALID && LPM_DATA[1:0] == ~$past(LOCK_PROG))
        else $error("lock bits wrong");
    a_fuse_low: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        lpm_cfg && ptr_q == CFG_FUSE_LOW |=> LPM_DATA == ~$past(FUSE_LOW_PROG))
        else $error("low fuse byte wrong");
    a_normal_load: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        LPM_EXEC && cmd_q == CMD_NONE |=> LPM_DATA == $past(FLASH_RD_DATA))
        else $error("normal load wrong");
    a_rww_zero: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        apb_setup && !PWRITE && PADDR == OFS_CTRL |=> PRDATA[BIT_RWW] == 1'b0)
        else $error("rww busy bit set");
    a_bad_cmd: assert property (@(posedge MCLK) disable iff (!sys_rst_n)
        ctrl_wr && !cmd_legal && cmd_q == CMD_NONE |=> cmd_q == CMD_NONE)
        else $error("illegal pattern took effect");
    a_stall_timer: assert property (@(posedge MCLK) disable iff (!por_rst_n)
        CORE_STALL == tmr_busy)
        else $error("stall differs from programming timer");
    c_erase_done: cover property (@(posedge MCLK) disable iff (!por_rst_n)
        op_q == OP_ERASE && tmr_done);
    c_write_done: cover property (@(posedge MCLK) disable iff (!por_rst_n) wr_done);
    c_buffer_load: cover property (@(posedge MCLK) disable iff (!sys_rst_n) pbuf.wr_en);
    c_fuse_read: cover property (@(posedge MCLK) disable iff (!sys_rst_n) lpm_cfg);
endmodule

/* testbench/core_model.sv */
// Core model: store and load pulses, program flash byte contents
`timescale 1ns/1ps
module core_model (
    input wire logic clk,
    input wire logic [15:0] rd_addr,
    output logic spm_exec,
    output logic lpm_exec,
    output logic [7:0] rd_data
);
    // Flash byte differs between the two bytes of one word
    assign rd_data = rd_addr[7:0] ^ rd_addr[15:8] ^ 8'h5A;
    initial begin
        spm_exec = 1'b0;
        lpm_exec = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Interrupts stay off, so the gap before the pulse is exactly what is asked
    task automatic pulse(input logic is_store, input int gap);
        repeat (gap) @(posedge clk);
        if (is_store) begin
            spm_exec <= 1'b1;
        end else begin
            lpm_exec <= 1'b1;
        end
        @(posedge clk);
        spm_exec <= 1'b0;
        lpm_exec <= 1'b0;
    endtask
endmodule

/* testbench/self_program_flash_ctrl_bench.sv */
// Bench for the sequencer: APB tasks, core pulses, flash-side monitor
`timescale 1ns/1ps
module self_program_flash_ctrl_bench;
    import spf_pkg::*;
    localparam int unsigned PROG_N = 50;
    localparam logic [9:0] PG = 10'h2A5;
    localparam logic [7:0] CFG [4] = '{8'h5A, 8'h02, 8'h3C, 8'h81};
    logic mclk = 1'b0;
    logic nrst = 1'b0;
    logic npor = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic ee_busy = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, v;
    logic pready, pslverr, last_err, spm_exec, lpm_exec, lpm_valid, stall, erase, wr_valid;
    logic [7:0] lpm_data, rd_data;
    logic [15:0] rd_addr, wr_data;
    logic [PAGE_W-1:0] page;
    logic [WORD_W-1:0] wr_word;
    logic [15:0] seen [32];
    logic [15:0] expw [32];
    int mismatches = 0;
    int total_checks = 0;
    int stall_cnt, wr_cnt, er_cnt;
    ////////////////////////////////////////////////////////////////////////////
    self_program_flash_ctrl #(.PROG_CYCLES_P(PROG_N)) self_program_flash_ctrl_inst (
        .MCLK(mclk), .NRST(nrst), .NPOR(npor), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .SPM_EXEC(spm_exec), .LPM_EXEC(lpm_exec), .LPM_DATA(lpm_data),
        .LPM_VALID(lpm_valid), .EEPROM_WRITE_BUSY(ee_busy), .FUSE_LOW_PROG(CFG[0]),
        .FUSE_HIGH_PROG(CFG[3]), .FUSE_EXT_PROG(CFG[2]), .LOCK_PROG(CFG[1][1:0]),
        .CORE_STALL(stall), .FLASH_RD_ADDR(rd_addr), .FLASH_RD_DATA(rd_data),
        .FLASH_ERASE(erase), .FLASH_WR_VALID(wr_valid), .FLASH_PAGE(page),
        .FLASH_WR_WORD(wr_word), .FLASH_WR_DATA(wr_data));
    core_model core_model_inst (.clk(mclk), .rd_addr(rd_addr), .spm_exec(spm_exec),
        .lpm_exec(lpm_exec), .rd_data(rd_data));
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        stall_cnt += (stall === 1'b1);
        er_cnt += (erase === 1'b1);
        if (wr_valid === 1'b1) begin
            seen[wr_word] = wr_data;
            wr_cnt++;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] seen_v, input logic [31:0] exp);
        total_checks++;
        if (seen_v !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen_v);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] r);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1) @(posedge mclk);
        r = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d, v);
    endtask
    task automatic set_ptr(input logic [15:0] p);
        wr(OFS_PTR_LO, {24'h0, p[7:0]});
        wr(OFS_PTR_HI, {24'h0, p[15:8]});
    endtask
    task automatic cmd(input logic [7:0] c, input logic st, input int gap);
        wr(OFS_CTRL, {24'h0, c});
        core_model_inst.pulse(st, gap);
    endtask
    task automatic store(input logic [4:0] w, input logic [15:0] d, input int gap);
        set_ptr({PG, w, 1'b1});
        wr(OFS_DATA_LO, {24'h0, d[7:0]});
        wr(OFS_DATA_HI, {24'h0, d[15:8]});
        cmd(8'h01, 1'b1, gap);
        expw[w] = d;
    endtask
    task automatic op(input logic [7:0] c, input int gap);
        #1 stall_cnt = 0;
        wr_cnt = 0;
        er_cnt = 0;
        set_ptr({PG, 6'h00});
        cmd(c, 1'b1, gap);
        apb(1'b0, OFS_CTRL, 32'h0, v);
        chk("enable while busy", v[0], 1'b1);
    endtask
    task automatic op_done(input int er, input int nw);
        for (int i = 0; i < 200 && stall !== 1'b0; i++) @(posedge mclk);
        chk("stall cycles", stall_cnt, PROG_N);
        chk("erase pulses", er_cnt, er);
        chk("word count", wr_cnt, nw);
        chk("page", page, PG);
        for (int i = 0; i < nw; i++) chk("word", seen[i], expw[i]);
    endtask
    task automatic no_op(input logic [7:0] c, input int gap);
        #1 stall_cnt = 0;
        cmd(c, 1'b1, gap);
        repeat (4) @(posedge mclk);
        chk("no stall", stall_cnt, 0);
        apb(1'b0, OFS_CTRL, 32'h0, v);
        chk("ctrl unchanged", v, 32'h0);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #100000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        npor <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, 8'h14, 32'h0, v);
        chk("unmapped error", last_err, 1'b1);
        for (int i = 0; i < 4; i++) begin
            set_ptr(16'(i));
            wr(OFS_CTRL, 32'h09);
            core_model_inst.pulse(1'b0, i % 3);
            #1;
            chk("config valid", lpm_valid, 1'b1);
            chk("config byte", lpm_data, 8'(~CFG[i]));
            apb(1'b0, OFS_CTRL, 32'h0, v);
            chk("arm cleared", v, 32'h0);
        end
        // Load one cycle past the read window falls back to a flash byte
        set_ptr(16'h0123);
        wr(OFS_CTRL, 32'h09);
        core_model_inst.pulse(1'b0, 3);
        #1;
        chk("flash addr", rd_addr, 16'h0123);
        chk("flash byte", lpm_data, 8'h78);
        @(posedge mclk);
        ee_busy <= 1'b1;
        wr(OFS_CTRL, 32'h09);
        core_model_inst.pulse(1'b0, 0);
        #1;
        chk("blocked read", lpm_data, 8'h78);
        no_op(8'h05, 0);
        ee_busy <= 1'b0;
        no_op(8'h07, 0);
        no_op(8'h15, 0);
        no_op(8'h05, 4);
        foreach (expw[i]) expw[i] = 16'hFFFF;
        store(5'd0, 16'h1234, 0);
        store(5'd7, 16'hA55A, 3);
        store(5'd31, 16'h0F0F, 3);
        apb(1'b0, OFS_PTR_HI, 32'h0, v);
        chk("pointer high", v, {24'h0, PG[9:2]});
        apb(1'b0, OFS_DATA_LO, 32'h0, v);
        chk("data low", v, 32'h0000_000F);
        op(8'h05, 1);
        op_done(0, 32);
        foreach (expw[i]) expw[i] = 16'hFFFF;
        op(8'h05, 0);
        repeat (10) @(posedge mclk);
        nrst <= 1'b0;
        repeat (3) @(posedge mclk);
        nrst <= 1'b1;
        op_done(0, 32);
        op(8'h03, 2);
        op_done(1, 0);
        store(5'd3, 16'hBEEF, 0);
        expw[3] = 16'hFFFF;
        cmd(8'h11, 1'b1, 0);
        op(8'h05, 0);
        op_done(0, 32);
        tally_and_finish();
    end
endmodule
